//--- dac_pkg.sv
// Constants and types for the DMA address, checksum and interrupt block
package dac_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_XFER_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_ADDR = 8'h04;
  localparam logic [7:0] OFS_DST_ADDR = 8'h08;
  localparam logic [7:0] OFS_BEAT_CNT = 8'h0C;
  localparam logic [7:0] OFS_CK_CTRL = 8'h10;
  localparam logic [7:0] OFS_CK_DIN = 8'h14;
  localparam logic [7:0] OFS_CK_VAL = 8'h18;
  localparam logic [7:0] OFS_CK_STAT = 8'h1C;
  localparam logic [7:0] OFS_CH_SEL = 8'h20;
  localparam logic [7:0] OFS_CH_FLAGS = 8'h24;
  localparam logic [7:0] OFS_CH_ENSET = 8'h28;
  localparam logic [7:0] OFS_CH_ENCLR = 8'h2C;
  localparam logic [7:0] OFS_PEND_VEC = 8'h30;
  localparam logic [7:0] OFS_LOW_PEND = 8'h34;
  // ==========================================================
  // Field positions
  localparam int XC_SRC_INC_BIT = 0;
  localparam int XC_DST_INC_BIT = 1;
  localparam int XC_STEP_SEL_BIT = 2;
  localparam int XC_STEP_LSB = 4;
  localparam int XC_BEAT_LSB = 8;
  localparam int CK_WIDTH_LSB = 0;
  localparam int CK_POLY_BIT = 2;
  localparam int CK_CHEN_BIT = 3;
  localparam int CK_CHAN_LSB = 4;
  localparam int FL_DONE = 0;
  localparam int FL_ERR = 1;
  localparam int FL_HALT = 2;
  localparam int LP_FLAGS_LSB = 8;
  localparam int LP_ANY_BIT = 31;
  // ==========================================================
  // Sizes and reset values
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam logic [31:0] XC_RST = 32'h0000_0000;
  localparam logic [7:0] CK_CTRL_RST = 8'h00;
  localparam logic [31:0] CRC32_SEED = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC16_SEED = 32'h0000_FFFF;
  localparam logic [31:0] POLY32 = 32'h04C1_1DB7;
  localparam logic [31:0] POLY16 = 32'h0000_1021;
  // ==========================================================
  // Checksum item widths and engine states
  typedef enum logic [1:0] {DAC_W8, DAC_W16, DAC_W32} dac_width_t;
  typedef enum {DAC_CK_IDLE, DAC_CK_RUN} dac_ck_state_t;
endpackage

//--- dac_top.sv
// DMA address stepping, checksum engine and channel interrupt logic
`timescale 1ns/100ps
module dac_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Beat sequencing from the channel engine
  input wire logic beat_load,
  input wire logic beat_next,
  output logic [31:0] src_addr_o,
  output logic [31:0] dst_addr_o,
  // Channel data passing to the checksum engine
  input wire logic chan_data_valid,
  input wire logic [dac_pkg::CH_W-1:0] chan_data_id,
  input wire logic [31:0] chan_data,
  output logic checksum_busy,
  // Channel events
  input wire logic [dac_pkg::NUM_CH-1:0] ch_block_done,
  input wire logic [dac_pkg::NUM_CH-1:0] ch_bus_error,
  input wire logic [dac_pkg::NUM_CH-1:0] ch_bad_desc,
  input wire logic [dac_pkg::NUM_CH-1:0] ch_suspended,
  input wire logic [dac_pkg::NUM_CH-1:0] ch_reset,
  // Combined interrupt
  output logic irq
);
  localparam int N = dac_pkg::NUM_CH;

  // ==========================================================
  // Register file
  logic [31:0] xfer_ctrl_r;
  logic [31:0] src_address_r;
  logic [31:0] dst_address_r;
  logic [15:0] beat_count_r;
  logic [7:0] ck_ctrl_r;
  logic [dac_pkg::CH_W-1:0] ch_sel_r;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_ctrl_r <= dac_pkg::XC_RST;
      src_address_r <= 32'h0000_0000;
      dst_address_r <= 32'h0000_0000;
      beat_count_r <= 16'h0000;
      ck_ctrl_r <= dac_pkg::CK_CTRL_RST;
      ch_sel_r <= '0;
    end else if (wr_acc) begin
      case (paddr)
        dac_pkg::OFS_XFER_CTRL: xfer_ctrl_r <= pwdata;
        dac_pkg::OFS_SRC_ADDR: src_address_r <= pwdata;
        dac_pkg::OFS_DST_ADDR: dst_address_r <= pwdata;
        dac_pkg::OFS_BEAT_CNT: beat_count_r <= pwdata[15:0];
        dac_pkg::OFS_CK_CTRL: ck_ctrl_r <= pwdata[7:0];
        dac_pkg::OFS_CH_SEL: ch_sel_r <= pwdata[dac_pkg::CH_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Address stepping
  logic src_incr_en;
  logic dst_incr_en;
  logic step_target_sel;
  logic [2:0] step_exponent;
  logic [1:0] beat_width;
  logic [31:0] beat_bytes;
  logic [31:0] src_step;
  logic [31:0] dst_step;
  logic [31:0] src_start;
  logic [31:0] dst_start;

  assign src_incr_en = xfer_ctrl_r[dac_pkg::XC_SRC_INC_BIT];
  assign dst_incr_en = xfer_ctrl_r[dac_pkg::XC_DST_INC_BIT];
  assign step_target_sel = xfer_ctrl_r[dac_pkg::XC_STEP_SEL_BIT];
  assign step_exponent = xfer_ctrl_r[dac_pkg::XC_STEP_LSB +: 3];
  assign beat_width = xfer_ctrl_r[dac_pkg::XC_BEAT_LSB +: 2];
  assign beat_bytes = {30'h0000_0000, beat_width} + 32'h0000_0001;
  // Source takes the programmed step only when step select is one
  assign src_step = step_target_sel ? (beat_bytes << step_exponent)
                                    : beat_bytes;
  assign dst_step = step_target_sel ? beat_bytes
                                    : (beat_bytes << step_exponent);
  // Start derived from the programmed end address
  assign src_start = src_incr_en ? src_address_r -
    32'(beat_count_r * src_step) : src_address_r;
  assign dst_start = dst_incr_en ? dst_address_r -
    32'(beat_count_r * dst_step) : dst_address_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_addr_o <= 32'h0000_0000;
      dst_addr_o <= 32'h0000_0000;
    end else if (beat_load) begin
      src_addr_o <= src_start;
      dst_addr_o <= dst_start;
    end else if (beat_next) begin
      if (src_incr_en) begin
        src_addr_o <= src_addr_o + src_step;
      end
      if (dst_incr_en) begin
        dst_addr_o <= dst_addr_o + dst_step;
      end
    end
  end

  // ==========================================================
  // Checksum engine
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d,
                                           input logic wide);
    logic [31:0] v;
    logic fb;
    v = c;
    for (int i = 7; i >= 0; i--) begin
      fb = (wide ? v[31] : v[15]) ^ d[i];
      v = v << 1;
      if (fb) begin
        v = v ^ (wide ? dac_pkg::POLY32 : dac_pkg::POLY16);
      end
    end
    if (!wide) begin
      v[31:16] = 16'h0000;
    end
    return v;
  endfunction

  dac_pkg::dac_ck_state_t ck_state_r;
  logic [31:0] ck_val_r;
  logic [31:0] ck_shift_r;
  logic [2:0] ck_left_r;
  logic ck_wide;
  logic ck_sw_ld;
  logic ck_ch_ld;
  logic [2:0] ck_bytes;

  assign ck_wide = ck_ctrl_r[dac_pkg::CK_POLY_BIT];
  // Data-in writes ignored while busy
  assign ck_sw_ld = wr_acc && paddr == dac_pkg::OFS_CK_DIN &&
                    ck_state_r == dac_pkg::DAC_CK_IDLE;
  assign ck_ch_ld = chan_data_valid && ck_ctrl_r[dac_pkg::CK_CHEN_BIT] &&
    chan_data_id == ck_ctrl_r[dac_pkg::CK_CHAN_LSB +: dac_pkg::CH_W] &&
    ck_state_r == dac_pkg::DAC_CK_IDLE && !ck_sw_ld;

  always_comb begin
    case (ck_ctrl_r[dac_pkg::CK_WIDTH_LSB +: 2])
      dac_pkg::DAC_W8: ck_bytes = 3'h1;
      dac_pkg::DAC_W16: ck_bytes = 3'h2;
      default: ck_bytes = 3'h4;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_state_r <= dac_pkg::DAC_CK_IDLE;
      ck_val_r <= dac_pkg::CRC32_SEED;
      ck_shift_r <= 32'h0000_0000;
      ck_left_r <= 3'h0;
    end else begin
      case (ck_state_r)
        dac_pkg::DAC_CK_IDLE: begin
          if (ck_sw_ld || ck_ch_ld) begin
            ck_shift_r <= ck_sw_ld ? pwdata : chan_data;
            ck_left_r <= ck_bytes;
            ck_state_r <= dac_pkg::DAC_CK_RUN;
          end else if (wr_acc && paddr == dac_pkg::OFS_CK_VAL) begin
            ck_val_r <= pwdata;
          end else if (wr_acc && paddr == dac_pkg::OFS_CK_CTRL) begin
            ck_val_r <= pwdata[dac_pkg::CK_POLY_BIT] ? dac_pkg::CRC32_SEED
                                                     : dac_pkg::CRC16_SEED;
          end
        end
        dac_pkg::DAC_CK_RUN: begin
          // One byte per cycle, low byte first
          ck_val_r <= crc_byte(ck_val_r, ck_shift_r[7:0], ck_wide);
          ck_shift_r <= ck_shift_r >> 8;
          ck_left_r <= ck_left_r - 3'h1;
          if (ck_left_r == 3'h1) begin
            ck_state_r <= dac_pkg::DAC_CK_IDLE;
          end
        end
        default: ck_state_r <= dac_pkg::DAC_CK_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      checksum_busy <= 1'b0;
    end else begin
      checksum_busy <= (ck_state_r == dac_pkg::DAC_CK_IDLE) ?
        (ck_sw_ld | ck_ch_ld) : (ck_left_r != 3'h1);
    end
  end

  // ==========================================================
  // Channel interrupt flags and enables
  logic [2:0] fl_r [N];
  logic [2:0] en_r [N];
  logic [N-1:0] halt_d_r;
  logic [N-1:0] pend;
  logic [dac_pkg::CH_W-1:0] low_ch;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_d_r <= '0;
      for (int c = 0; c < N; c++) begin
        fl_r[c] <= 3'h0;
        en_r[c] <= 3'h0;
      end
    end else begin
      halt_d_r <= ch_suspended;
      for (int c = 0; c < N; c++) begin
        if (ch_reset[c]) begin
          fl_r[c] <= 3'h0;
          en_r[c] <= 3'h0;
        end else begin
          // Clear by one, then events set on top
          fl_r[c] <= (fl_r[c] &
            ~((wr_acc && paddr == dac_pkg::OFS_CH_FLAGS &&
               ch_sel_r == c) ? pwdata[2:0] : 3'h0)) |
            {ch_suspended[c] & ~halt_d_r[c],
             ch_bus_error[c] | ch_bad_desc[c],
             ch_block_done[c]};
          if (wr_acc && ch_sel_r == c &&
              paddr == dac_pkg::OFS_CH_ENSET) begin
            en_r[c] <= en_r[c] | pwdata[2:0];
          end else if (wr_acc && ch_sel_r == c &&
                       paddr == dac_pkg::OFS_CH_ENCLR) begin
            en_r[c] <= en_r[c] & ~pwdata[2:0];
          end
        end
      end
    end
  end

  always_comb begin
    low_ch = '0;
    for (int c = N - 1; c >= 0; c--) begin
      pend[c] = |(fl_r[c] & en_r[c]);
      if (pend[c]) begin
        low_ch = dac_pkg::CH_W'(c);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |pend;
    end
  end

  // ==========================================================
  // APB read path, one wait-free access phase
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      dac_pkg::OFS_XFER_CTRL: rd_mux = xfer_ctrl_r;
      dac_pkg::OFS_SRC_ADDR: rd_mux = src_address_r;
      dac_pkg::OFS_DST_ADDR: rd_mux = dst_address_r;
      dac_pkg::OFS_BEAT_CNT: rd_mux = {16'h0000, beat_count_r};
      dac_pkg::OFS_CK_CTRL: rd_mux = {24'h000000, ck_ctrl_r};
      dac_pkg::OFS_CK_DIN: rd_mux = 32'h0000_0000;
      dac_pkg::OFS_CK_VAL: rd_mux = ck_val_r;
      dac_pkg::OFS_CK_STAT: rd_mux = {31'h0, checksum_busy};
      dac_pkg::OFS_CH_SEL: rd_mux = 32'(ch_sel_r);
      dac_pkg::OFS_CH_FLAGS: rd_mux = {29'h0, fl_r[ch_sel_r]};
      dac_pkg::OFS_CH_ENSET: rd_mux = {29'h0, en_r[ch_sel_r]};
      dac_pkg::OFS_CH_ENCLR: rd_mux = {29'h0, en_r[ch_sel_r]};
      dac_pkg::OFS_PEND_VEC: rd_mux = 32'(pend);
      dac_pkg::OFS_LOW_PEND: begin
        rd_mux = 32'(low_ch);
        rd_mux[dac_pkg::LP_FLAGS_LSB +: 3] = fl_r[low_ch];
        rd_mux[dac_pkg::LP_ANY_BIT] = |pend;
      end
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SRC_ONE_BEAT: assert property (
    beat_next && !beat_load && src_incr_en && !step_target_sel |=>
    src_addr_o == $past(src_addr_o) + $past(beat_bytes))
    else $error("source step is not one beat");
  AST_SRC_END: assert property (
    beat_load && src_incr_en |=>
    src_addr_o + 32'($past(beat_count_r) * $past(src_step)) ==
    $past(src_address_r))
    else $error("source start does not reach end address");
  AST_DST_FIXED: assert property (
    !dst_incr_en && !beat_load |=> $stable(dst_addr_o))
    else $error("destination moved while increment disabled");
  AST_DST_STEP: assert property (
    beat_next && !beat_load && dst_incr_en |=>
    dst_addr_o - $past(dst_addr_o) == ($past(step_target_sel) ?
    $past(beat_bytes) : $past(beat_bytes) << $past(step_exponent)))
    else $error("destination step wrong");
  AST_DST_END: assert property (
    beat_load && dst_incr_en |=>
    dst_addr_o + 32'($past(beat_count_r) * $past(dst_step)) ==
    $past(dst_address_r))
    else $error("destination start does not reach end address");
  AST_CK_FOUR: assert property (
    ck_sw_ld && ck_bytes == 3'h4 |=> checksum_busy[*4] ##1 !checksum_busy)
    else $error("word not taken in four cycles");
  AST_CK_CHAN: assert property (
    ck_ch_ld |=> checksum_busy && ck_state_r == dac_pkg::DAC_CK_RUN)
    else $error("channel item not taken by checksum");
  AST_CK_HOLD: assert property (
    ck_state_r == dac_pkg::DAC_CK_IDLE && !wr_acc |=> $stable(ck_val_r))
    else $error("checksum changed while idle");
  AST_DONE_SET: assert property (
    ch_block_done[0] && !ch_reset[0] |=> fl_r[0][dac_pkg::FL_DONE])
    else $error("complete flag not set");
  AST_ERR_SET: assert property (
    (ch_bus_error[1] || ch_bad_desc[1]) && !ch_reset[1] |=>
    fl_r[1][dac_pkg::FL_ERR])
    else $error("error flag not set");
  AST_HALT_SET: assert property (
    $rose(ch_suspended[0]) && !ch_reset[0] |=> fl_r[0][dac_pkg::FL_HALT])
    else $error("suspend flag not set");
  AST_IRQ_OR: assert property (
    |pend |=> irq)
    else $error("pending channel did not raise interrupt");
  AST_IRQ_LOW: assert property (
    !(|pend) |=> !irq)
    else $error("interrupt without pending channel");

  COV_WORD: cover property (ck_sw_ld ##5 !checksum_busy);
  COV_IRQ: cover property (ch_block_done[2] ##1 pend[2] ##1 irq);
  COV_STEP: cover property (beat_load ##1 beat_next ##1 beat_next);
endmodule

//--- dac_chan_model.sv
// Channel engine model driving beats, channel data and channel events
`timescale 1ns/100ps
module dac_chan_model (
  // Clock and checksum status
  input wire logic pclk,
  input wire logic checksum_busy,
  // Beat sequencing
  output logic beat_load,
  output logic beat_next,
  // Channel data
  output logic chan_data_valid,
  output logic [dac_pkg::CH_W-1:0] chan_data_id,
  output logic [31:0] chan_data,
  // Channel events
  output logic [dac_pkg::NUM_CH-1:0] ch_block_done,
  output logic [dac_pkg::NUM_CH-1:0] ch_bus_error,
  output logic [dac_pkg::NUM_CH-1:0] ch_bad_desc,
  output logic [dac_pkg::NUM_CH-1:0] ch_suspended,
  output logic [dac_pkg::NUM_CH-1:0] ch_reset
);
  initial begin
    beat_load = 1'b0;
    beat_next = 1'b0;
    chan_data_valid = 1'b0;
    chan_data_id = '0;
    chan_data = 32'h5A5A_5A5A;
    ch_block_done = '0;
    ch_bus_error = '0;
    ch_bad_desc = '0;
    ch_suspended = '0;
    ch_reset = '0;
  end
  // ==========
  // Beat pulses, called just after an edge
  task automatic beat(input logic load);
    if (load) beat_load <= 1'b1;
    else beat_next <= 1'b1;
    @(posedge pclk);
    beat_load <= 1'b0;
    beat_next <= 1'b0;
  endtask
  // ==========
  // One data item through a channel
  task automatic send_item(input logic [dac_pkg::CH_W-1:0] id,
                           input logic [31:0] d);
    @(posedge pclk);
    while (checksum_busy !== 1'b0) begin
      @(posedge pclk);
    end
    chan_data_valid <= 1'b1;
    chan_data_id <= id;
    chan_data <= d;
    @(posedge pclk);
    chan_data_valid <= 1'b0;
    chan_data <= ~d;
  endtask
  // ==========
  // Event pulse: 0 done, 1 bus error, 2 bad descriptor, 3 halt, 4 reset
  task automatic pulse_event(input int kind,
                             input logic [dac_pkg::NUM_CH-1:0] mask);
    case (kind)
      0: ch_block_done <= mask;
      1: ch_bus_error <= mask;
      2: ch_bad_desc <= mask;
      3: ch_suspended <= mask;
      default: ch_reset <= mask;
    endcase
    @(posedge pclk);
    ch_block_done <= '0;
    ch_bus_error <= '0;
    ch_bad_desc <= '0;
    ch_suspended <= '0;
    ch_reset <= '0;
  endtask
endmodule

//--- dma_addr_crc_irq_tb_top.sv
// Self-checking testbench for the address, checksum and interrupt block
`timescale 1ns/100ps
module dma_addr_crc_irq_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic beat_load, beat_next, chan_data_valid, checksum_busy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, chan_data, src_addr_o, dst_addr_o, rd;
  logic [dac_pkg::CH_W-1:0] chan_data_id;
  logic [dac_pkg::NUM_CH-1:0] ch_block_done, ch_bus_error, ch_bad_desc;
  logic [dac_pkg::NUM_CH-1:0] ch_suspended, ch_reset;
  int n_mismatch = 0;
  int n_tests = 0;
  int busy_cycles = 0;

  dac_top dac_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .beat_load, .beat_next,
    .src_addr_o, .dst_addr_o, .chan_data_valid, .chan_data_id, .chan_data,
    .checksum_busy, .ch_block_done, .ch_bus_error, .ch_bad_desc,
    .ch_suspended, .ch_reset, .irq);
  dac_chan_model dac_chan_model_i (.pclk, .checksum_busy, .beat_load,
    .beat_next, .chan_data_valid, .chan_data_id, .chan_data,
    .ch_block_done, .ch_bus_error, .ch_bad_desc, .ch_suspended, .ch_reset);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (checksum_busy === 1'b1) busy_cycles++;
  end
  // ==========
  // Helpers
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    psel <= 1'b0;
    @(posedge pclk);
    chk(nm, e, rd);
  endtask
  function automatic logic [31:0] crc8(input logic [31:0] c,
                                       input logic [7:0] b, input logic w);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = (w ? c[31] : c[15]) ^ b[i];
      c = {c[30:0], 1'b0};
      if (fb) c = c ^ (w ? dac_pkg::POLY32 : dac_pkg::POLY16);
    end
    return w ? c : {16'h0, c[15:0]};
  endfunction
  function automatic logic [31:0] crcw(input logic [31:0] c,
                                       input logic [31:0] d);
    for (int i = 0; i < 4; i++) c = crc8(c, d[8*i +: 8], 1'b1);
    return c;
  endfunction
  // ==========
  // Scenarios
  task automatic t_reset();
    rchk("xfer_ctrl", dac_pkg::OFS_XFER_CTRL, dac_pkg::XC_RST);
    rchk("ck_value", dac_pkg::OFS_CK_VAL, dac_pkg::CRC32_SEED);
    rchk("pend_vec", dac_pkg::OFS_PEND_VEC, 32'h0);
    rchk("unmapped", 8'h3C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("irq_idle", 32'h0, {31'h0, irq});
  endtask
  task automatic t_addr(input logic [31:0] ctrl, input logic [31:0] ss,
                        input logic [31:0] ds);
    wr(dac_pkg::OFS_XFER_CTRL, ctrl);
    wr(dac_pkg::OFS_SRC_ADDR, 32'h0000_1000 + 5 * ss);
    wr(dac_pkg::OFS_DST_ADDR, 32'h0002_0000 + 5 * ds);
    wr(dac_pkg::OFS_BEAT_CNT, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      dac_chan_model_i.beat(i == 0);
      @(negedge pclk);
      chk("src_addr", 32'h0000_1000 + i * ss, src_addr_o);
      chk("dst_addr", 32'h0002_0000 + i * ds, dst_addr_o);
      @(posedge pclk);
    end
  endtask
  task automatic t_crc_reg(input logic [31:0] ctrl, input logic [31:0] d,
                           input int nb);
    logic [31:0] e;
    e = ctrl[2] ? dac_pkg::CRC32_SEED : dac_pkg::CRC16_SEED;
    wr(dac_pkg::OFS_CK_CTRL, ctrl);
    busy_cycles = 0;
    wr(dac_pkg::OFS_CK_DIN, d);
    repeat (8) @(posedge pclk);
    chk("busy_cycles", nb, busy_cycles);
    for (int i = 0; i < nb; i++) e = crc8(e, d[8*i +: 8], ctrl[2]);
    rchk("ck_value", dac_pkg::OFS_CK_VAL, e);
  endtask
  task automatic t_crc_drop();
    wr(dac_pkg::OFS_CK_CTRL, 32'h0000_0006);
    apb(1'b1, dac_pkg::OFS_CK_DIN, 32'h0123_4567);
    apb(1'b1, dac_pkg::OFS_CK_DIN, 32'hFFFF_0000);
    apb(1'b0, dac_pkg::OFS_CK_STAT, 32'h0);
    psel <= 1'b0;
    chk("busy_stat", 32'h1, rd);
    repeat (6) @(posedge pclk);
    wr(dac_pkg::OFS_CK_DIN, 32'h89AB_CDEF);
    repeat (6) @(posedge pclk);
    rchk("ck_drop", dac_pkg::OFS_CK_VAL, crcw(crcw(dac_pkg::CRC32_SEED,
      32'h0123_4567), 32'h89AB_CDEF));
  endtask
  task automatic t_crc_chan();
    wr(dac_pkg::OFS_CK_CTRL, 32'h0000_002E);
    dac_chan_model_i.send_item(2'h2, 32'hCAFE_F00D);
    dac_chan_model_i.send_item(2'h1, 32'h1111_2222);
    dac_chan_model_i.send_item(2'h2, 32'h0BAD_BEEF);
    repeat (6) @(posedge pclk);
    rchk("ck_chan", dac_pkg::OFS_CK_VAL, crcw(crcw(dac_pkg::CRC32_SEED,
      32'hCAFE_F00D), 32'h0BAD_BEEF));
  endtask
  task automatic t_irq(input int ch, input int kind, input int fl);
    logic [31:0] fb;
    fb = 32'h1 << fl;
    wr(dac_pkg::OFS_CH_SEL, 32'(ch));
    wr(dac_pkg::OFS_CH_ENSET, fb);
    dac_chan_model_i.pulse_event(kind, 4'h1 << ch);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    @(posedge pclk);
    rchk("flags", dac_pkg::OFS_CH_FLAGS, fb);
    rchk("pend_vec", dac_pkg::OFS_PEND_VEC, 32'h1 << ch);
    rchk("lowest", dac_pkg::OFS_LOW_PEND,
      32'h8000_0000 | (fb << 8) | 32'(ch));
    wr(dac_pkg::OFS_CH_FLAGS, fb);
    rchk("flags_clr", dac_pkg::OFS_CH_FLAGS, 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask
  task automatic t_irq_prio();
    wr(dac_pkg::OFS_CH_SEL, 32'h3);
    wr(dac_pkg::OFS_CH_ENSET, 32'h1);
    rchk("en3", dac_pkg::OFS_CH_ENSET, 32'h5);
    wr(dac_pkg::OFS_CH_SEL, 32'h1);
    wr(dac_pkg::OFS_CH_ENCLR, 32'h2);
    dac_chan_model_i.pulse_event(0, 4'hA);
    repeat (3) @(posedge pclk);
    rchk("vec3", dac_pkg::OFS_PEND_VEC, 32'h8);
    rchk("low3", dac_pkg::OFS_LOW_PEND, 32'h8000_0103);
    wr(dac_pkg::OFS_CH_ENSET, 32'h1);
    rchk("low1", dac_pkg::OFS_LOW_PEND, 32'h8000_0101);
    dac_chan_model_i.pulse_event(4, 4'h2);
    repeat (2) @(posedge pclk);
    rchk("low_rst", dac_pkg::OFS_LOW_PEND, 32'h8000_0103);
    rchk("en_rst", dac_pkg::OFS_CH_ENSET, 32'h0);
    wr(dac_pkg::OFS_CH_SEL, 32'h3);
    wr(dac_pkg::OFS_CH_ENCLR, 32'h1);
    rchk("flag3", dac_pkg::OFS_CH_FLAGS, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_addr(32'h0000_0117, 32'h4, 32'h2);
    t_addr(32'h0000_0323, 32'h4, 32'h10);
    t_addr(32'h0000_0031, 32'h1, 32'h0);
    t_crc_reg(32'h0000_0000, 32'h0000_00A5, 1);
    t_crc_reg(32'h0000_0001, 32'h0000_1234, 2);
    t_crc_reg(32'h0000_0006, 32'hDEAD_BEEF, 4);
    t_crc_drop();
    t_crc_chan();
    t_irq(0, 0, dac_pkg::FL_DONE);
    t_irq(1, 1, dac_pkg::FL_ERR);
    t_irq(2, 2, dac_pkg::FL_ERR);
    t_irq(3, 3, dac_pkg::FL_HALT);
    t_irq_prio();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
